// >>> shared/irm_pkg.sv
// Constants and carrier types for the ingress rate meter configuration block.
// Assumes a classic Wishbone slave with 32-bit data and one clock domain.
package irm_pkg;
   localparam logic [15:0] IRM_OFS_SETUP = 16'h184A;
   localparam logic [15:0] IRM_OFS_CMD = 16'h184B;
   localparam logic [15:0] IRM_OFS_STS = 16'h184C;
   localparam logic [15:0] IRM_OFS_WDATA = 16'h184D;
   localparam logic [15:0] IRM_OFS_RDATA = 16'h184E;
   localparam int IRM_ADDR_SHIFT = 2;
   localparam int IRM_NUM_RATE = 24;
   localparam int IRM_CMD_DIR_BIT = 7;
   localparam int IRM_CMD_TYPE_LSB = 5;
   localparam int IRM_CMD_IDX_LSB = 0;
   localparam int IRM_SETUP_MODE_LSB = 1;
   localparam int IRM_SETUP_EN_BIT = 0;
   localparam logic [15:0] IRM_RST_BURST = 16'h0600;
   localparam logic [15:0] IRM_RST_RATE = 16'h0014;
   localparam logic [1:0] IRM_RST_MODE = 2'h0;
   localparam int IRM_RATE_UNIT_NS = 20;
   localparam int IRM_CLK_PERIOD_NS = 25;
   // Wait-state cycles per table access; pending stands one cycle longer, three in all
   localparam logic [1:0] IRM_ACCESS_CYCLES = 2'h2;
   localparam logic [4:0] IRM_GROUP_SIZE = 5'h08;

   typedef enum logic [1:0] {
      IRM_MODE_PORT_PRIO = 2'h0,
      IRM_MODE_PORT = 2'h1,
      IRM_MODE_PRIO = 2'h2,
      IRM_MODE_RSVD = 2'h3
   } irm_mode_t;

   typedef enum logic [1:0] {
      IRM_TBL_RSVD = 2'h0,
      IRM_TBL_RATE = 2'h1,
      IRM_TBL_CBS = 2'h2,
      IRM_TBL_EBS = 2'h3
   } irm_tbl_t;

   typedef enum logic [1:0] {
      IRM_ST_IDLE = 2'h0,
      IRM_ST_WAIT = 2'h1,
      IRM_ST_DONE = 2'h3
   } irm_state_t;

   typedef struct packed {
      logic dir_read;
      irm_tbl_t tbl;
      logic [4:0] idx;
   } irm_cmd_t;

   typedef struct packed {
      logic [31:0] adr;
      logic [31:0] dat;
      logic [3:0] sel;
      logic we;
      logic cyc;
      logic stb;
   } irm_wb_req_t;
endpackage

// >>> logic/irm_table.sv
// Metering table storage: 24 rate entries and two burst sizes.
// Assumes at most one access request per cycle from the sequencer.
module irm_table (
   input wire logic i_clk, // Core clock
   input wire logic i_rst, // Async reset, high
   input wire logic i_req, // Access strobe
   input wire irm_pkg::irm_cmd_t i_cmd, // Access selection
   input wire logic [15:0] i_wdata, // Write value
   input wire logic [4:0] i_look_idx, // Meter lookup index
   output logic [15:0] o_rdata, // Read value
   output logic [15:0] o_look_rate, // Rate for lookup
   output logic [15:0] o_cbs, // Committed burst
   output logic [15:0] o_ebs // Excess burst
);
   logic [15:0] rate [irm_pkg::IRM_NUM_RATE];
   logic [15:0] cbs;
   logic [15:0] ebs;
   wire idx_ok = i_cmd.idx < 5'(irm_pkg::IRM_NUM_RATE);
   wire look_ok = i_look_idx < 5'(irm_pkg::IRM_NUM_RATE);
   wire do_wr = i_req && !i_cmd.dir_read;
   logic [15:0] sel_val;

   always_comb begin
      case (i_cmd.tbl)
         irm_pkg::IRM_TBL_RATE: sel_val = idx_ok ? rate[i_cmd.idx] : 16'h0000;
         irm_pkg::IRM_TBL_CBS: sel_val = cbs;
         irm_pkg::IRM_TBL_EBS: sel_val = ebs;
         default: sel_val = 16'h0000;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int k = 0; k < irm_pkg::IRM_NUM_RATE; k++) begin
            rate[k] <= irm_pkg::IRM_RST_RATE;
         end
         cbs <= irm_pkg::IRM_RST_BURST;
         ebs <= irm_pkg::IRM_RST_BURST;
         o_rdata <= 16'h0000;
         o_look_rate <= irm_pkg::IRM_RST_RATE;
      end else begin
         if (do_wr && i_cmd.tbl == irm_pkg::IRM_TBL_RATE && idx_ok) begin
            rate[i_cmd.idx] <= i_wdata;
         end
         if (do_wr && i_cmd.tbl == irm_pkg::IRM_TBL_CBS) begin
            cbs <= i_wdata;
         end
         if (do_wr && i_cmd.tbl == irm_pkg::IRM_TBL_EBS) begin
            ebs <= i_wdata;
         end
         if (i_req && i_cmd.dir_read) begin
            o_rdata <= sel_val;
         end
         o_look_rate <= look_ok ? rate[i_look_idx] : 16'h0000;
      end
   end

   assign o_cbs = cbs;
   assign o_ebs = ebs;

   a_write_lands: assert property (@(posedge i_clk) disable iff (i_rst)
      do_wr && i_cmd.tbl == irm_pkg::IRM_TBL_CBS |=> o_cbs == $past(i_wdata))
      else $error("Committed burst write lost");
   a_read_keeps: assert property (@(posedge i_clk) disable iff (i_rst)
      i_req && !i_cmd.dir_read |=> $stable(o_rdata))
      else $error("Write disturbed read data");
endmodule // irm_table

// >>> logic/irm_bucket.sv
// One token bucket with a byte-count ceiling; debit by packet, credit by tick.
// Assumes ticks come from the meter's rate divider in the same clock domain.
module irm_bucket (
   input wire logic i_clk, // Core clock
   input wire logic i_rst, // Async reset, high
   input wire logic i_tick, // One-byte credit pulse
   input wire logic i_take, // Debit strobe
   input wire logic [15:0] i_len, // Debit bytes
   input wire logic [15:0] i_limit, // Programmed ceiling
   output logic [15:0] o_level, // Current tokens
   output logic o_short // Not enough for i_len
);
   logic [15:0] level;
   wire below = level < i_limit;
   wire [15:0] credited = (i_tick && below) ? 16'(level + 16'h0001) : level;
   wire short = i_len > level;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         level <= irm_pkg::IRM_RST_BURST;
      end else if (i_take && !short) begin
         level <= 16'(credited - i_len);
      end else begin
         // Refill stops at limit; a higher level drains normally
         level <= credited;
      end
   end

   assign o_level = level;
   assign o_short = short;

   a_no_overfill: assert property (@(posedge i_clk) disable iff (i_rst)
      !i_take && $past(level) >= $past(i_limit) && !$past(i_take) |-> level <= $past(level))
      else $error("Bucket grew above its limit");
endmodule // irm_bucket

// >>> logic/irm_meter_cfg.sv
// Top of the ingress meter configuration: Wishbone registers, command sequencer,
// table and the pair of token buckets for the packet presented for metering.
// Assumes the packet side offers one packet strobe with port, priority, length.
//
// The implementer's own choice: register access over Wishbone.
module irm_meter_cfg (
   input wire logic I_CLK, // 40 MHz core clock
   input wire logic I_RST, // Async reset, high
   input wire logic i_WB_CYC, // Wishbone cycle
   input wire logic i_WB_STB, // Wishbone strobe
   input wire logic i_WB_WE, // Wishbone write
   input wire logic [31:0] i_WB_ADR, // Byte address
   input wire logic [31:0] i_WB_DAT, // Write data
   input wire logic [3:0] i_WB_SEL, // Byte enables
   input wire logic i_PKT_VALID, // Packet to meter, pulse
   input wire logic [1:0] i_PKT_PORT, // Source port
   input wire logic [4:0] i_PKT_PRIO, // Packet priority
   input wire logic [15:0] i_PKT_LEN, // Packet bytes
   output logic [31:0] o_WB_DAT, // Read data
   output logic o_WB_ACK, // Wishbone ack
   output logic o_METER_EN, // Metering active
   output logic [1:0] o_METER_MODE, // Granularity mode
   output logic o_PKT_DONE, // Verdict strobe
   output logic o_PKT_RED, // Drop verdict
   output logic o_PKT_YELLOW // Random-drop candidate
);
   logic meter_en;
   irm_pkg::irm_mode_t mode;
   irm_pkg::irm_cmd_t cmd;
   logic [15:0] wvalue;
   logic pending;
   logic [1:0] wait_cnt;
   irm_pkg::irm_state_t state;
   irm_pkg::irm_state_t next_state;
   logic [15:0] rvalue;
   logic [15:0] look_rate;
   logic [15:0] cbs;
   logic [15:0] ebs;
   logic [15:0] tick_cnt;
   logic pkt_stage;
   logic [15:0] pkt_len;
   logic c_short;
   logic e_short;

   // Bus decode; a request is answered one cycle after it appears
   wire [29:0] word = i_WB_ADR[31:irm_pkg::IRM_ADDR_SHIFT];
   wire req = i_WB_CYC && i_WB_STB && !o_WB_ACK;
   wire wr = req && i_WB_WE;
   wire lo_lane = i_WB_SEL[0];
   wire hit_setup = word == 30'(irm_pkg::IRM_OFS_SETUP);
   wire hit_cmd = word == 30'(irm_pkg::IRM_OFS_CMD);
   wire hit_sts = word == 30'(irm_pkg::IRM_OFS_STS);
   wire hit_wdata = word == 30'(irm_pkg::IRM_OFS_WDATA);
   wire hit_rdata = word == 30'(irm_pkg::IRM_OFS_RDATA);
   wire wr_setup = wr && hit_setup && lo_lane;
   // Command write while pending is ignored so an access is never torn
   wire wr_cmd = wr && hit_cmd && lo_lane && !pending;
   wire [15:0] wv_next = {i_WB_SEL[1] ? i_WB_DAT[15:8] : wvalue[15:8],
                          lo_lane ? i_WB_DAT[7:0] : wvalue[7:0]};
   wire wr_wdata = wr && hit_wdata;
   wire [31:0] rd_setup = {29'h0, mode, meter_en};
   wire [31:0] rd_cmd = {24'h0, cmd};
   wire [31:0] rd_sts = {31'h0, pending};
   wire [31:0] rd_wdata = {16'h0, wvalue};
   wire [31:0] rd_rdata = {16'h0, rvalue};
   wire [31:0] rd_mux = hit_setup ? rd_setup :
                        hit_cmd ? rd_cmd :
                        hit_sts ? rd_sts :
                        hit_wdata ? rd_wdata :
                        hit_rdata ? rd_rdata : 32'h0000_0000;
   wire irm_pkg::irm_cmd_t cmd_in = i_WB_DAT[7:0];

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         o_WB_ACK <= 1'b0;
         o_WB_DAT <= 32'h0000_0000;
      end else begin
         o_WB_ACK <= req;
         o_WB_DAT <= (req && !i_WB_WE) ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         meter_en <= 1'b0;
         mode <= irm_pkg::irm_mode_t'(irm_pkg::IRM_RST_MODE);
         cmd <= '0;
         wvalue <= 16'h0000;
      end else begin
         if (wr_setup) begin
            meter_en <= i_WB_DAT[irm_pkg::IRM_SETUP_EN_BIT];
            mode <= irm_pkg::irm_mode_t'(i_WB_DAT[irm_pkg::IRM_SETUP_MODE_LSB +: 2]);
         end
         if (wr_cmd) begin
            cmd <= cmd_in;
         end
         if (wr_wdata) begin
            wvalue <= wv_next;
         end
      end
   end

   // Command sequencer; fixed latency keeps polling software honest
   wire seq_wait = state == irm_pkg::IRM_ST_WAIT;
   wire wait_over = seq_wait && wait_cnt == 2'h0;
   always_comb begin
      case (state)
         irm_pkg::IRM_ST_IDLE: next_state = wr_cmd ? irm_pkg::IRM_ST_WAIT : state;
         irm_pkg::IRM_ST_WAIT: next_state = wait_over ? irm_pkg::IRM_ST_DONE : state;
         irm_pkg::IRM_ST_DONE: next_state = irm_pkg::IRM_ST_IDLE;
         default: next_state = irm_pkg::IRM_ST_IDLE;
      endcase
   end

   wire tbl_req = state == irm_pkg::IRM_ST_DONE;

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         state <= irm_pkg::IRM_ST_IDLE;
         pending <= 1'b0;
         wait_cnt <= 2'h0;
      end else begin
         state <= next_state;
         wait_cnt <= wr_cmd ? 2'(irm_pkg::IRM_ACCESS_CYCLES - 2'h1) :
                     (seq_wait ? 2'(wait_cnt - 2'h1) : wait_cnt);
         pending <= wr_cmd ? 1'b1 : (tbl_req ? 1'b0 : pending);
      end
   end

   // Meter index lookup per granularity mode
   wire [4:0] grp = (i_PKT_PORT == 2'h2) ? 5'(2 * irm_pkg::IRM_GROUP_SIZE) :
                    (i_PKT_PORT == 2'h1) ? irm_pkg::IRM_GROUP_SIZE : 5'h00;
   wire [4:0] idx_pp = 5'(grp + {2'h0, i_PKT_PRIO[2:0]});
   wire [4:0] idx_p = {3'h0, i_PKT_PORT};
   wire [4:0] idx_q = i_PKT_PRIO;
   wire [4:0] look_idx = (mode == irm_pkg::IRM_MODE_PORT) ? idx_p :
                         (mode == irm_pkg::IRM_MODE_PRIO) ? idx_q : idx_pp;

   irm_table u_table (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .i_req(tbl_req),
      .i_cmd(cmd),
      .i_wdata(wvalue),
      .i_look_idx(look_idx),
      .o_rdata(rvalue),
      .o_look_rate(look_rate),
      .o_cbs(cbs),
      .o_ebs(ebs)
   );

   // Rate divider: one byte credit per (rate+1)*20 ns, approximated in 25 ns cycles
   wire [31:0] rate_ns = 32'(({16'h0, look_rate} + 32'h1) * irm_pkg::IRM_RATE_UNIT_NS);
   wire [15:0] rate_cyc = 16'(rate_ns / irm_pkg::IRM_CLK_PERIOD_NS);
   wire byte_tick = meter_en && tick_cnt >= rate_cyc;
   wire take = pkt_stage && meter_en;

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         tick_cnt <= 16'h0000;
         pkt_stage <= 1'b0;
         pkt_len <= 16'h0000;
      end else begin
         tick_cnt <= byte_tick ? 16'h0000 : 16'(tick_cnt + 16'h0001);
         pkt_stage <= i_PKT_VALID;
         if (i_PKT_VALID) begin
            pkt_len <= i_PKT_LEN;
         end
      end
   end

   irm_bucket u_commit (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .i_tick(byte_tick),
      .i_take(take),
      .i_len(pkt_len),
      .i_limit(cbs),
      .o_level(),
      .o_short(c_short)
   );

   irm_bucket u_excess (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .i_tick(byte_tick),
      .i_take(take && c_short),
      .i_len(pkt_len),
      .i_limit(ebs),
      .o_level(),
      .o_short(e_short)
   );

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         o_PKT_DONE <= 1'b0;
         o_PKT_RED <= 1'b0;
         o_PKT_YELLOW <= 1'b0;
         o_METER_EN <= 1'b0;
         o_METER_MODE <= 2'h0;
      end else begin
         o_PKT_DONE <= pkt_stage;
         o_PKT_YELLOW <= take && c_short && !e_short;
         o_PKT_RED <= take && c_short && e_short;
         o_METER_EN <= meter_en;
         o_METER_MODE <= mode;
      end
   end

   sequence s_cmd_write;
      wr_cmd;
   endsequence
   sequence s_busy_then_done;
      pending [*3] ##1 !pending;
   endsequence

   a_pending_span: assert property (@(posedge I_CLK) disable iff (I_RST)
      s_cmd_write |=> s_busy_then_done)
      else $error("Pending flag span wrong");
   a_cmd_starts: assert property (@(posedge I_CLK) disable iff (I_RST)
      s_cmd_write |=> seq_wait && cmd == $past(cmd_in))
      else $error("Command write did not start access");
   a_read_result: assert property (@(posedge I_CLK) disable iff (I_RST)
      tbl_req && cmd.dir_read && cmd.tbl == irm_pkg::IRM_TBL_CBS |=> rvalue == cbs)
      else $error("Read data not the selected entry");
   a_ack_once: assert property (@(posedge I_CLK) disable iff (I_RST)
      o_WB_ACK |=> !o_WB_ACK)
      else $error("Ack held two cycles");
   a_disabled_pass: assert property (@(posedge I_CLK) disable iff (I_RST)
      !meter_en |=> !o_PKT_RED && !o_PKT_YELLOW)
      else $error("Verdict while metering off");
   a_mode_port: assert property (@(posedge I_CLK) disable iff (I_RST)
      mode == irm_pkg::IRM_MODE_PORT |-> look_idx == {3'h0, i_PKT_PORT})
      else $error("Port-only index wrong");
   a_mode_pp: assert property (@(posedge I_CLK) disable iff (I_RST)
      mode == irm_pkg::IRM_MODE_PORT_PRIO && i_PKT_PORT == 2'h1 && i_PKT_PRIO == 5'h00
      |-> look_idx == 5'h08)
      else $error("Port+priority group wrong");
   a_dir_write: assert property (@(posedge I_CLK) disable iff (I_RST)
      tbl_req && !cmd.dir_read && cmd.tbl == irm_pkg::IRM_TBL_EBS |=> ebs == $past(wvalue))
      else $error("Table write missed");
endmodule // irm_meter_cfg

// >>> bench/test_irm_meter_cfg.sv
// Self-checking bench for the ingress meter configuration block.
// Assumes the Wishbone slave answers each request with a one-cycle ack.
module test_irm_meter_cfg;
   timeunit 1ns;
   timeprecision 100ps;

   logic I_CLK = 1'b0;
   logic I_RST = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [31:0] wb_adr = 32'h0;
   logic [31:0] wb_wdat = 32'h0;
   logic [3:0] wb_sel = 4'h0;
   logic pkt_valid = 1'b0;
   logic [1:0] pkt_port = 2'h0;
   logic [4:0] pkt_prio = 5'h00;
   logic [15:0] pkt_len = 16'h0000;
   logic [31:0] wb_rdat;
   logic wb_ack;
   logic meter_en;
   logic [1:0] meter_mode;
   logic pkt_done;
   logic pkt_red;
   logic pkt_yellow;
   integer mismatches = 0;
   integer tests_run = 0;
   integer seed = 32'h2fd4;
   logic [15:0] tbl_model [0:25];

   always #12.5 I_CLK = ~I_CLK;

   irm_meter_cfg DUT (
      .I_CLK(I_CLK), .I_RST(I_RST), .i_WB_CYC(wb_cyc), .i_WB_STB(wb_stb), .i_WB_WE(wb_we),
      .i_WB_ADR(wb_adr), .i_WB_DAT(wb_wdat), .i_WB_SEL(wb_sel), .i_PKT_VALID(pkt_valid),
      .i_PKT_PORT(pkt_port), .i_PKT_PRIO(pkt_prio), .i_PKT_LEN(pkt_len), .o_WB_DAT(wb_rdat),
      .o_WB_ACK(wb_ack), .o_METER_EN(meter_en), .o_METER_MODE(meter_mode),
      .o_PKT_DONE(pkt_done), .o_PKT_RED(pkt_red), .o_PKT_YELLOW(pkt_yellow)
   );

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_flag(input string what, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic timed_out(input string what);
      mismatches++;
      $display("[FAIL] %s expected completion seen timeout", what);
      final_report();
   endtask

   // Table slot in the bench model: rates 0-23, committed 24, excess 25
   function automatic int slot_of(input logic [1:0] typ, input logic [4:0] idx);
      return (typ == 2'h1) ? int'(idx) : (typ == 2'h2) ? 24 : 25;
   endfunction

   // Classic single cycle; request held until ack is sampled
   task automatic wb_xfer(input logic we, input logic [15:0] off, input logic [31:0] wd,
                          output logic [31:0] rd);
      int k;
      @(posedge I_CLK);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= {14'h0000, off, 2'h0};
      wb_wdat <= wd;
      wb_sel <= 4'hF;
      for (k = 0; k < 16; k++) begin
         @(posedge I_CLK);
         if (wb_ack === 1'b1) break;
      end
      rd = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      if (k == 16) timed_out("bus ack");
   endtask

   task automatic reg_wr(input logic [15:0] off, input logic [31:0] wd);
      logic [31:0] dummy;
      wb_xfer(1'b1, off, wd, dummy);
   endtask

   task automatic reg_rd(input logic [15:0] off, output logic [31:0] rd);
      wb_xfer(1'b0, off, 32'h0, rd);
   endtask

   // One indirect access; polls pending before fetching the result
   task automatic tbl_op(input logic rd_dir, input logic [1:0] typ, input logic [4:0] idx,
                         input logic [15:0] wv, output logic [31:0] rv);
      logic [31:0] st;
      int k;
      if (!rd_dir) reg_wr(irm_pkg::IRM_OFS_WDATA, {16'h0000, wv});
      reg_wr(irm_pkg::IRM_OFS_CMD, {24'h000000, rd_dir, typ, idx});
      reg_rd(irm_pkg::IRM_OFS_STS, st);
      check_flag("pending after command", 1'b1, st[0]);
      // No new command until pending clears
      for (k = 0; k < 20; k++) begin
         reg_rd(irm_pkg::IRM_OFS_STS, st);
         if (st[0] === 1'b0) break;
      end
      if (k == 20) timed_out("pending clear");
      rv = 32'h0;
      if (rd_dir) reg_rd(irm_pkg::IRM_OFS_RDATA, rv);
   endtask

   // Verdict stands two cycles after the valid cycle: one edge after the sampling edge
   task automatic send_pkt(input logic [15:0] len, input logic exp_done, input logic exp_red,
                           input logic exp_yellow);
      int k;
      logic seen;
      @(posedge I_CLK);
      pkt_valid <= 1'b1;
      pkt_port <= 2'h0;
      pkt_prio <= 5'h00;
      pkt_len <= len;
      seen = 1'b0;
      for (k = 0; k < 6; k++) begin
         @(posedge I_CLK);
         pkt_valid <= 1'b0;
         #1;
         seen = seen | pkt_red | pkt_yellow;
         if (exp_done && pkt_done === 1'b1) break;
      end
      if (exp_done) begin
         check_reg("verdict latency", 32'd1, k);
         check_flag("red verdict", exp_red, pkt_red);
         check_flag("yellow verdict", exp_yellow, pkt_yellow);
      end else begin
         check_flag("verdict while disabled", 1'b0, seen);
      end
   endtask

   initial begin
      logic [31:0] rd;
      logic [1:0] typ;
      logic [4:0] idx;
      logic [15:0] val;
      logic en;
      int i;
      int picks [6] = '{0, 7, 8, 16, 23, 24};
      for (i = 0; i < 26; i++) tbl_model[i] = (i < 24) ? irm_pkg::IRM_RST_RATE
                                                         : irm_pkg::IRM_RST_BURST;
      repeat (2) @(posedge I_CLK);
      I_RST <= 1'b0;
      reg_rd(irm_pkg::IRM_OFS_SETUP, rd);
      check_reg("setup after reset", 32'h0, rd);
      check_flag("enable after reset", 1'b0, meter_en);
      reg_rd(irm_pkg::IRM_OFS_STS, rd);
      check_reg("status after reset", 32'h0, rd);
      reg_wr(irm_pkg::IRM_OFS_RDATA, 32'hFFFFFFFF);
      reg_rd(irm_pkg::IRM_OFS_RDATA, rd);
      check_reg("read value after reset", 32'h0, rd);
      reg_rd(16'h1849, rd);
      check_reg("unmapped read", 32'h0, rd);
      // Reset contents, excess burst read through the type 11 slot
      for (i = 0; i < 7; i++) begin
         typ = (i == 6) ? 2'h3 : (i == 5) ? 2'h2 : 2'h1;
         tbl_op(1'b1, typ, picks[(i == 6) ? 5 : i][4:0], 16'h0, rd);
         check_reg("table reset value", {16'h0, tbl_model[slot_of(typ, picks[i % 6][4:0])]},
                   rd);
      end
      // Oversized packet while metering is off gives no verdict
      send_pkt(16'h07D0, 1'b0, 1'b0, 1'b0);
      // Burst sizes stay at 0600h, above every metered packet below
      reg_wr(irm_pkg::IRM_OFS_SETUP, 32'h00000001);
      send_pkt(16'h03E8, 1'b1, 1'b0, 1'b0);
      // Committed bucket now short, excess still full
      send_pkt(16'h03E8, 1'b1, 1'b0, 1'b1);
      send_pkt(16'h03E8, 1'b1, 1'b1, 1'b0);
      // A red packet takes no tokens, so a smaller one still fits
      send_pkt(16'h01F4, 1'b1, 1'b0, 1'b0);
      for (i = 0; i < 4; i++) begin
         en = ~i[0];
         reg_wr(irm_pkg::IRM_OFS_SETUP, {$random(seed)} & 32'hFFFFFFF8 | {29'h0, i[1:0], en});
         reg_rd(irm_pkg::IRM_OFS_SETUP, rd);
         check_reg("setup readback", {29'h0, i[1:0], en}, rd);
         check_reg("mode output", {30'h0, i[1:0]}, {30'h0, meter_mode});
         check_flag("enable output", en, meter_en);
      end
      // Random writes, reserved type included, then full readback
      for (i = 0; i < 26; i++) begin
         typ = (i < 2) ? 2'h1 : 2'($random(seed));
         idx = (i == 0) ? 5'd23 : (i == 1) ? 5'd0 : 5'({$random(seed)} % 24);
         val = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($random(seed));
         tbl_op(1'b0, typ, idx, val, rd);
         if (typ != 2'h0) tbl_model[slot_of(typ, idx)] = val;
      end
      for (i = 0; i < 26; i++) begin
         typ = (i < 24) ? 2'h1 : (i == 24) ? 2'h2 : 2'h3;
         tbl_op(1'b1, typ, 5'(i % 24), 16'h0, rd);
         check_reg("table readback", {16'h0, tbl_model[i]}, rd);
      end
      final_report();
   end
endmodule // test_irm_meter_cfg
